// [logic/wdt_defines.vh]
// Constants for the watchdog / interval timer: addresses, fields, resets, periods.
// Assumes inclusion by bare name from the design files that use it; protect_seq does not include it.
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH

// ==========================================================
// Register addresses (byte addresses, 8-bit data)
`define WDT_ADDR_PERIOD_SEL 32'hfffff6c1
`define WDT_ADDR_MODE 32'hfffff6c2
`define WDT_ADDR_RESET_CAUSE 32'hfffff6c3
`define WDT_ADDR_PROTECT_CMD 32'hfffff6c4
`define WDT_ADDR_SYS_STATUS 32'hfffff6c5
`define WDT_ADDR_IRQ_CTRL 32'hfffff6c6

// ==========================================================
// Field positions
`define WDT_MODE_RUN_BIT 7
`define WDT_MODE_UPPER_BIT 4
`define WDT_MODE_LOWER_BIT 3
`define WDT_RESET_FLAG_BIT 0
`define WDT_PROTECT_ERR_BIT 0
`define WDT_IRQ_REQ_BIT 7
`define WDT_IRQ_MASK_BIT 6
`define WDT_IRQ_PRIO_MSB 2
`define WDT_IRQ_PRIO_LSB 0

// ==========================================================
// Reset values
`define WDT_RST_PERIOD_SEL 3'h0
`define WDT_RST_MODE 2'h0
`define WDT_RST_IRQ_PRIO 3'h7

// ==========================================================
// Overflow periods in peripheral clock cycles, one per select code
`define WDT_PERIOD_0 16384
`define WDT_PERIOD_1 32768
`define WDT_PERIOD_2 65536
`define WDT_PERIOD_3 131072
`define WDT_PERIOD_4 262144
`define WDT_PERIOD_5 524288
`define WDT_PERIOD_6 1048576
`define WDT_PERIOD_7 4194304

`endif

// [logic/period_divider.v]
// Half-rate count clock, overflow counter and period tap selection.
// Assumes one clock; clear and enable come from the timer core.
`include "wdt_defines.vh"

module period_divider #(
  parameter P0 = `WDT_PERIOD_0,
  parameter P1 = `WDT_PERIOD_1,
  parameter P2 = `WDT_PERIOD_2,
  parameter P3 = `WDT_PERIOD_3,
  parameter P4 = `WDT_PERIOD_4,
  parameter P5 = `WDT_PERIOD_5,
  parameter P6 = `WDT_PERIOD_6,
  parameter P7 = `WDT_PERIOD_7
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_sys_rst,
  // Control
  input wire i_clear,
  input wire i_count_en,
  input wire [2:0] i_sel,
  // Event
  output reg o_overflow
);

  // ==========================================================
  // Terminal counts in half-rate ticks; longest one still fits 21 bits
  localparam [31:0] T0_FULL = P0 / 2 - 1;
  localparam [31:0] T1_FULL = P1 / 2 - 1;
  localparam [31:0] T2_FULL = P2 / 2 - 1;
  localparam [31:0] T3_FULL = P3 / 2 - 1;
  localparam [31:0] T4_FULL = P4 / 2 - 1;
  localparam [31:0] T5_FULL = P5 / 2 - 1;
  localparam [31:0] T6_FULL = P6 / 2 - 1;
  localparam [31:0] T7_FULL = P7 / 2 - 1;
  localparam [20:0] T0 = T0_FULL[20:0];
  localparam [20:0] T1 = T1_FULL[20:0];
  localparam [20:0] T2 = T2_FULL[20:0];
  localparam [20:0] T3 = T3_FULL[20:0];
  localparam [20:0] T4 = T4_FULL[20:0];
  localparam [20:0] T5 = T5_FULL[20:0];
  localparam [20:0] T6 = T6_FULL[20:0];
  localparam [20:0] T7 = T7_FULL[20:0];

  reg phase_ff;
  reg [20:0] cnt_ff;
  reg [20:0] term;

  always @* begin
    case (i_sel)
      3'h0: term = T0;
      3'h1: term = T1;
      3'h2: term = T2;
      3'h3: term = T3;
      3'h4: term = T4;
      3'h5: term = T5;
      3'h6: term = T6;
      default: term = T7;
    endcase
  end

  // ==========================================================
  // Counter; >= so a shorter period chosen mid-count still fires
  always @(posedge i_mclk) begin
    if (i_sys_rst || i_clear) begin
      phase_ff <= 1'b0;
      cnt_ff <= 21'h0;
      o_overflow <= 1'b0;
    end else if (i_count_en) begin
      phase_ff <= ~phase_ff;
      o_overflow <= 1'b0;
      if (phase_ff) begin
        if (cnt_ff >= term) begin
          cnt_ff <= 21'h0;
          o_overflow <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 21'h1;
        end
      end
    end else begin
      o_overflow <= 1'b0;
    end
  end

endmodule // period_divider

// [logic/protect_seq.v]
// Protected-write sequencer: a command write arms the next write only.
// Assumes write strobes are one cycle long and synchronous to the clock.
module protect_seq (
  // Clock and reset
  input wire i_mclk,
  input wire i_sys_rst,
  // Bus writes
  input wire i_any_wr,
  input wire i_cmd_wr,
  input wire i_special_wr,
  // Verdict
  output wire o_write_ok,
  output wire o_write_bad
);

  reg armed_ff;

  // Any write other than the command itself consumes the arming
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      armed_ff <= 1'b0;
    end else if (i_any_wr) begin
      armed_ff <= i_cmd_wr;
    end
  end

  assign o_write_ok = i_special_wr & armed_ff;
  assign o_write_bad = i_special_wr & ~armed_ff;

endmodule // protect_seq

// [logic/watchdog_interval_timer.v]
// Watchdog / interval timer core with its byte-wide register port.
// Assumes a synchronous bus master and standby status from the system.
//
// Function
// - Reset clears mode and reset-cause registers: stopped, interval mode, flag clear.
// - Mode register writes need the protect sequence; byte or bit access.
// - Run bit 7: zero stops; writing one clears counter and starts.
// - Software cannot clear run; only reset clears it.
// - Mode bits 4:3: 0x interval irq, 10 NMI, 11 system reset.
// - After run is set, software cannot clear either mode bit.
// - Unprotected reset-cause write is dropped; protect error flag set.
// - Reset-cause register written as bytes, read as bytes or bits.
// - Flag set by watchdog reset; cleared by writing 0 or reset pin.
// - Watchdog mode: rewriting run within period restarts count from zero.
// - Watchdog timeout gives reset or NMI per low mode bit.
// - Watchdog counting halts in software STOP or IDLE.
// - Period is 2^14..2^20 or 2^22 clocks by select code.
// - Interval mode raises maskable irq each overflow, gated by mask; priority is only output.
// - Interval irq holds highest default maskable priority.
// - Interval counting continues in HALT, stops in STOP and IDLE.
// - Counter runs at half peripheral clock through tap-selected divider.
// - Period select register: code in low three bits, rest zero.
//
// Implementation choice: strobed register access.
`include "wdt_defines.vh"

module watchdog_interval_timer #(
  parameter PERIOD_0 = `WDT_PERIOD_0,
  parameter PERIOD_1 = `WDT_PERIOD_1,
  parameter PERIOD_2 = `WDT_PERIOD_2,
  parameter PERIOD_3 = `WDT_PERIOD_3,
  parameter PERIOD_4 = `WDT_PERIOD_4,
  parameter PERIOD_5 = `WDT_PERIOD_5,
  parameter PERIOD_6 = `WDT_PERIOD_6,
  parameter PERIOD_7 = `WDT_PERIOD_7
) (
  // Clock and external reset pin
  input wire i_mclk,
  input wire i_sys_rst,
  // Register port
  input wire [31:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // Standby status
  input wire i_stop_idle,
  // Overflow events
  output reg o_dog_system_reset,
  output reg o_dog_nmi_request,
  output reg o_interval_irq_request,
  // Status levels
  output wire [2:0] o_interval_irq_priority,
  output wire o_protect_error_flag,
  output wire o_running
);

  // ==========================================================
  // Address decode
  wire sel_period;
  wire sel_mode;
  wire sel_cause;
  wire sel_cmd;
  wire sel_sys;
  wire sel_irq;

  assign sel_period = (i_addr == `WDT_ADDR_PERIOD_SEL);
  assign sel_mode = (i_addr == `WDT_ADDR_MODE);
  assign sel_cause = (i_addr == `WDT_ADDR_RESET_CAUSE);
  assign sel_cmd = (i_addr == `WDT_ADDR_PROTECT_CMD);
  assign sel_sys = (i_addr == `WDT_ADDR_SYS_STATUS);
  assign sel_irq = (i_addr == `WDT_ADDR_IRQ_CTRL);

  wire wr_period;
  wire wr_sys;
  wire wr_irq;

  assign wr_period = i_wr & sel_period;
  assign wr_sys = i_wr & sel_sys;
  assign wr_irq = i_wr & sel_irq;

  // ==========================================================
  // State registers
  reg run_ff;
  reg [1:0] mode_ff;
  reg [2:0] period_sel_ff;
  reg dog_flag_ff;
  reg prot_err_ff;
  reg irq_req_ff;
  reg irq_mask_ff;
  reg [2:0] irq_prio_ff;

  reg nxt_run;
  reg [1:0] nxt_mode;
  reg [2:0] nxt_period_sel;
  reg nxt_dog_flag;
  reg nxt_prot_err;
  reg nxt_irq_req;
  reg nxt_irq_mask;
  reg [2:0] nxt_irq_prio;

  // ==========================================================
  // Protected write sequencing
  wire mode_ok;
  wire mode_bad;
  wire cause_ok;
  wire cause_bad;

  // A watchdog reset also disarms a pending protect command
  protect_seq u_prot_mode (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst | o_dog_system_reset),
    .i_any_wr(i_wr),
    .i_cmd_wr(i_wr & sel_cmd),
    .i_special_wr(i_wr & sel_mode),
    .o_write_ok(mode_ok),
    .o_write_bad(mode_bad)
  );

  protect_seq u_prot_cause (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst | o_dog_system_reset),
    .i_any_wr(i_wr),
    .i_cmd_wr(i_wr & sel_cmd),
    .i_special_wr(i_wr & sel_cause),
    .o_write_ok(cause_ok),
    .o_write_bad(cause_bad)
  );

  // ==========================================================
  // Counter control
  wire restart;
  wire count_en;
  wire overflow;

  // Every accepted run=1 write clears the counter, also while running
  assign restart = mode_ok & i_wdata[`WDT_MODE_RUN_BIT];

  // HALT is not an input: counting simply goes on through it
  assign count_en = run_ff & ~i_stop_idle;

  period_divider #(
    .P0(PERIOD_0),
    .P1(PERIOD_1),
    .P2(PERIOD_2),
    .P3(PERIOD_3),
    .P4(PERIOD_4),
    .P5(PERIOD_5),
    .P6(PERIOD_6),
    .P7(PERIOD_7)
  ) u_div (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst | o_dog_system_reset),
    .i_clear(restart),
    .i_count_en(count_en),
    .i_sel(period_sel_ff),
    .o_overflow(overflow)
  );

  // ==========================================================
  // Overflow action decode
  wire ovf_interval;
  wire ovf_nmi;
  wire ovf_reset;

  // A restart in the overflow cycle wins: the timeout was met in time
  assign ovf_interval = overflow & ~restart & ~mode_ff[1];
  assign ovf_nmi = overflow & ~restart & (mode_ff == 2'h2);
  assign ovf_reset = overflow & ~restart & (mode_ff == 2'h3);

  // ==========================================================
  // Next-state logic for software-visible state
  always @* begin
    nxt_run = run_ff;
    nxt_mode = mode_ff;
    nxt_period_sel = period_sel_ff;
    nxt_dog_flag = dog_flag_ff;
    nxt_prot_err = prot_err_ff;
    nxt_irq_req = irq_req_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_irq_prio = irq_prio_ff;

    // Mode register: run and mode bits are sticky once running
    if (mode_ok) begin
      nxt_run = run_ff | i_wdata[`WDT_MODE_RUN_BIT];
      if (run_ff) begin
        nxt_mode = mode_ff | {i_wdata[`WDT_MODE_UPPER_BIT], i_wdata[`WDT_MODE_LOWER_BIT]};
      end else begin
        nxt_mode = {i_wdata[`WDT_MODE_UPPER_BIT], i_wdata[`WDT_MODE_LOWER_BIT]};
      end
    end

    if (wr_period) begin
      nxt_period_sel = i_wdata[2:0];
    end

    // Reset-cause flag: only a zero takes effect; hardware set wins
    if (cause_ok && !i_wdata[`WDT_RESET_FLAG_BIT]) begin
      nxt_dog_flag = 1'b0;
    end
    if (o_dog_system_reset) begin
      nxt_dog_flag = 1'b1;
    end

    // Protect error: cleared by writing zero, any bad write sets it
    if (wr_sys && !i_wdata[`WDT_PROTECT_ERR_BIT]) begin
      nxt_prot_err = 1'b0;
    end
    if (mode_bad || cause_bad) begin
      nxt_prot_err = 1'b1;
    end

    // Interrupt control: request cleared by writing zero, set wins
    if (wr_irq) begin
      nxt_irq_mask = i_wdata[`WDT_IRQ_MASK_BIT];
      nxt_irq_prio = i_wdata[`WDT_IRQ_PRIO_MSB:`WDT_IRQ_PRIO_LSB];
      if (!i_wdata[`WDT_IRQ_REQ_BIT]) begin
        nxt_irq_req = 1'b0;
      end
    end
    if (ovf_interval) begin
      nxt_irq_req = 1'b1;
    end
  end

  // ==========================================================
  // State update; a watchdog reset clears the block except the flag
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      run_ff <= 1'b0;
      mode_ff <= `WDT_RST_MODE;
      period_sel_ff <= `WDT_RST_PERIOD_SEL;
      dog_flag_ff <= 1'b0;
      prot_err_ff <= 1'b0;
      irq_req_ff <= 1'b0;
      irq_mask_ff <= 1'b1;
      irq_prio_ff <= `WDT_RST_IRQ_PRIO;
    end else if (o_dog_system_reset) begin
      run_ff <= 1'b0;
      mode_ff <= `WDT_RST_MODE;
      period_sel_ff <= `WDT_RST_PERIOD_SEL;
      dog_flag_ff <= 1'b1;
      prot_err_ff <= 1'b0;
      irq_req_ff <= 1'b0;
      irq_mask_ff <= 1'b1;
      irq_prio_ff <= `WDT_RST_IRQ_PRIO;
    end else begin
      run_ff <= nxt_run;
      mode_ff <= nxt_mode;
      period_sel_ff <= nxt_period_sel;
      dog_flag_ff <= nxt_dog_flag;
      prot_err_ff <= nxt_prot_err;
      irq_req_ff <= nxt_irq_req;
      irq_mask_ff <= nxt_irq_mask;
      irq_prio_ff <= nxt_irq_prio;
    end
  end

  // ==========================================================
  // Event outputs, one cycle each
  always @(posedge i_mclk) begin
    if (i_sys_rst || o_dog_system_reset) begin
      o_dog_system_reset <= 1'b0;
      o_dog_nmi_request <= 1'b0;
      o_interval_irq_request <= 1'b0;
    end else begin
      o_dog_system_reset <= ovf_reset;
      o_dog_nmi_request <= ovf_nmi;
      // Top default rank is left to the system arbiter's fixed order
      o_interval_irq_request <= ovf_interval & ~irq_mask_ff;
    end
  end

  assign o_interval_irq_priority = irq_prio_ff;
  assign o_protect_error_flag = prot_err_ff;
  assign o_running = run_ff;

  // ==========================================================
  // Read port: data one cycle after the strobe, zero otherwise
  reg [7:0] rd_mux;

  always @* begin
    rd_mux = 8'h00;
    if (sel_period) begin
      rd_mux[2:0] = period_sel_ff;
    end else if (sel_mode) begin
      rd_mux[`WDT_MODE_RUN_BIT] = run_ff;
      rd_mux[`WDT_MODE_UPPER_BIT] = mode_ff[1];
      rd_mux[`WDT_MODE_LOWER_BIT] = mode_ff[0];
    end else if (sel_cause) begin
      rd_mux[`WDT_RESET_FLAG_BIT] = dog_flag_ff;
    end else if (sel_sys) begin
      rd_mux[`WDT_PROTECT_ERR_BIT] = prot_err_ff;
    end else if (sel_irq) begin
      rd_mux[`WDT_IRQ_REQ_BIT] = irq_req_ff;
      rd_mux[`WDT_IRQ_MASK_BIT] = irq_mask_ff;
      rd_mux[`WDT_IRQ_PRIO_MSB:`WDT_IRQ_PRIO_LSB] = irq_prio_ff;
    end
  end

  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rd_mux;
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule // watchdog_interval_timer

// [verif/wdt_checker_sva.sv]
// Port checker for the watchdog / interval timer.
// Assumes the top module's port names; bound after endmodule.
`include "wdt_defines.vh"
module wdt_checker (
  input wire i_mclk,
  input wire i_sys_rst,
  input wire [31:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire i_stop_idle,
  input wire o_dog_system_reset,
  input wire o_dog_nmi_request,
  input wire o_interval_irq_request,
  input wire [2:0] o_interval_irq_priority,
  input wire o_protect_error_flag,
  input wire o_running
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  // ====================
  // Helpers
  reg armed_ff;
  wire evt = o_dog_system_reset | o_dog_nmi_request | o_interval_irq_request;
  // Writes in the reset pulse cycle are lost, so they are left out
  wire prot = i_wr && !o_dog_system_reset &&
    (i_addr == `WDT_ADDR_MODE || i_addr == `WDT_ADDR_RESET_CAUSE);
  always @(posedge i_mclk) begin
    if (i_sys_rst || o_dog_system_reset) armed_ff <= 1'b0;
    else if (i_wr) armed_ff <= (i_addr == `WDT_ADDR_PROTECT_CMD);
  end
  // ====================
  // Assertions
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_sys_pulse: assert property (o_dog_system_reset |=> !o_dog_system_reset)
    else $error("system reset longer than one cycle");
  a_nmi_pulse: assert property (o_dog_nmi_request |=> !o_dog_nmi_request)
    else $error("nmi longer than one cycle");
  a_irq_pulse: assert property (o_interval_irq_request |=> !o_interval_irq_request)
    else $error("irq longer than one cycle");
  a_evt_one_kind: assert property ($onehot0({o_dog_system_reset, o_dog_nmi_request, o_interval_irq_request}))
    else $error("two event kinds at once");
  a_evt_needs_run: assert property (evt |-> o_running)
    else $error("event while stopped");
  a_run_locked: assert property (o_running && !o_dog_system_reset |=> o_running)
    else $error("run cleared without reset");
  a_stop_quiet: assert property (i_stop_idle [*4] |-> !evt)
    else $error("event in standby");
  a_unprot_error: assert property (prot && !armed_ff |=> o_protect_error_flag)
    else $error("unprotected write without error");
  a_prot_run: assert property (prot && armed_ff && i_addr == `WDT_ADDR_MODE && i_wdata[7] |=> o_running)
    else $error("protected run write ignored");
  a_mode_reserved: assert property ($past(i_rd && i_addr == `WDT_ADDR_MODE) |-> (o_rdata & 8'h67) == 8'h00)
    else $error("reserved mode bits not zero");
  a_sel_upper: assert property ($past(i_rd && i_addr == `WDT_ADDR_PERIOD_SEL) |-> o_rdata[7:3] == 5'h00)
    else $error("select upper bits not zero");
  a_reset_vals: assert property ($fell(i_sys_rst) |-> !o_running && !o_protect_error_flag)
    else $error("bad state after reset");
  c_sys: cover property (o_dog_system_reset);
  c_nmi: cover property (o_dog_nmi_request);
  c_irq: cover property (o_interval_irq_request);
endmodule // wdt_checker

bind watchdog_interval_timer wdt_checker u_chk (
  .i_mclk(i_mclk),
  .i_sys_rst(i_sys_rst),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .o_rdata(o_rdata),
  .i_stop_idle(i_stop_idle),
  .o_dog_system_reset(o_dog_system_reset),
  .o_dog_nmi_request(o_dog_nmi_request),
  .o_interval_irq_request(o_interval_irq_request),
  .o_interval_irq_priority(o_interval_irq_priority),
  .o_protect_error_flag(o_protect_error_flag),
  .o_running(o_running)
);

// [verif/tb_watchdog_interval_timer.sv]
// Self-checking bench for the watchdog / interval timer.
// Assumes shortened periods by parameter and the shared address defines.
`include "wdt_defines.vh"
module tb_watchdog_interval_timer;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PER[8] = '{8, 16, 32, 64, 128, 256, 512, 1024};
  // Row: select code, mode bits, expected {sys, nmi, irq}
  localparam logic [7:0] ROWS[8] = '{8'b000_00_001, 8'b001_01_001, 8'b010_10_010, 8'b011_11_100,
    8'b100_00_001, 8'b101_10_010, 8'b110_11_100, 8'b111_01_001};
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [31:0] i_addr = 32'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_stop_idle = 1'b0;
  logic [7:0] o_rdata;
  logic [2:0] o_interval_irq_priority;
  logic o_dog_system_reset, o_dog_nmi_request, o_interval_irq_request, o_protect_error_flag, o_running;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  int n_evt = 0;
  int n, base, p;
  logic [7:0] rv;
  logic [2:0] ev;
  always #50 i_mclk = ~i_mclk;
  watchdog_interval_timer #(.PERIOD_0(PER[0]), .PERIOD_1(PER[1]), .PERIOD_2(PER[2]), .PERIOD_3(PER[3]),
    .PERIOD_4(PER[4]), .PERIOD_5(PER[5]), .PERIOD_6(PER[6]), .PERIOD_7(PER[7])) u_dut (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_stop_idle(i_stop_idle),
    .o_dog_system_reset(o_dog_system_reset), .o_dog_nmi_request(o_dog_nmi_request),
    .o_interval_irq_request(o_interval_irq_request), .o_interval_irq_priority(o_interval_irq_priority),
    .o_protect_error_flag(o_protect_error_flag), .o_running(o_running));
  // ====================
  // Event count and hang guard
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (o_dog_system_reset | o_dog_nmi_request | o_interval_irq_request) n_evt++;
    if (cycles == 30000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // ====================
  // Tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_in(input int v, input int lo, input int hi, input string what);
    checked++;
    if (v < lo || v > hi) begin
      mismatches++;
      $display("MISMATCH t=%0t %s %0d not in %0d..%0d", $time, what, v, lo, hi);
    end
  endtask
  // Strobes stay up between back-to-back calls; idle drops them
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_rd <= 1'b0;
    i_addr <= a;
    i_wdata <= d;
  endtask
  task automatic idle();
    @(posedge i_mclk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
  endtask
  task automatic pwr(input logic [31:0] a, input logic [7:0] d);
    wr(`WDT_ADDR_PROTECT_CMD, 8'h00);
    wr(a, d);
  endtask
  task automatic rd(input logic [31:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    i_addr <= a;
    idle();
    #1 d = o_rdata;
  endtask
  task automatic do_reset();
    @(posedge i_mclk);
    i_sys_rst <= 1'b1;
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    i_stop_idle <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
  endtask
  task automatic wait_evt(input int lim, output int cnt, output logic [2:0] e);
    cnt = 0;
    e = 3'b000;
    while (e === 3'b000 && cnt < lim) begin
      @(posedge i_mclk);
      #1 e = {o_dog_system_reset, o_dog_nmi_request, o_interval_irq_request};
      cnt++;
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ====================
  // Main sequence
  initial begin
    for (int k = 0; k < 8; k++) begin
      p = PER[ROWS[k][7:5]];
      do_reset();
      wr(`WDT_ADDR_PERIOD_SEL, {5'h00, ROWS[k][7:5]});
      wr(`WDT_ADDR_IRQ_CTRL, 8'h07);
      pwr(`WDT_ADDR_MODE, {3'b100, ROWS[k][4:3], 3'h0});
      idle();
      wait_evt(3000, n, ev);
      chk({5'h00, ev}, {5'h00, ROWS[k][2:0]}, "event kind");
      chk_in(n, p - 3, p + 3, "period");
      if (ROWS[k][2]) begin
        rd(`WDT_ADDR_RESET_CAUSE, rv);
        chk(rv, 8'h01, "reset flag");
        chk({7'h00, o_running}, 8'h00, "run after reset");
      end else if (ROWS[k][0]) begin
        wait_evt(3000, n, ev);
        chk_in(n, p - 1, p + 1, "repeat");
      end
      $display("row %0d done", k);
    end
    do_reset();
    rd(`WDT_ADDR_MODE, rv);
    chk(rv, 8'h00, "mode reset");
    chk({5'h00, o_interval_irq_priority}, 8'h07, "priority reset");
    rd(`WDT_ADDR_RESET_CAUSE, rv);
    chk(rv, 8'h00, "cause reset");
    rd(`WDT_ADDR_PERIOD_SEL, rv);
    chk(rv, 8'h00, "select reset");
    wr(`WDT_ADDR_PERIOD_SEL, 8'hff);
    rd(`WDT_ADDR_PERIOD_SEL, rv);
    chk(rv, 8'h07, "select width");
    // Mask stays set so the later run in interval mode stays quiet
    wr(`WDT_ADDR_IRQ_CTRL, 8'h43);
    idle();
    #1 chk({5'h00, o_interval_irq_priority}, 8'h03, "irq priority");
    wr(`WDT_ADDR_MODE, 8'h88);
    idle();
    #1 chk({6'h00, o_running, o_protect_error_flag}, 8'h01, "unprotected mode");
    pwr(`WDT_ADDR_MODE, 8'h67);
    rd(`WDT_ADDR_MODE, rv);
    chk(rv, 8'h00, "reserved bits");
    pwr(`WDT_ADDR_MODE, 8'h88);
    pwr(`WDT_ADDR_MODE, 8'h00);
    rd(`WDT_ADDR_MODE, rv);
    chk(rv, 8'h88, "run and mode lock");
    $display("register test done");
    do_reset();
    pwr(`WDT_ADDR_MODE, 8'h98);
    idle();
    wait_evt(100, n, ev);
    wr(`WDT_ADDR_SYS_STATUS, 8'h00);
    wr(`WDT_ADDR_RESET_CAUSE, 8'h00);
    rd(`WDT_ADDR_RESET_CAUSE, rv);
    chk(rv, 8'h01, "unprotected cause write");
    chk({7'h00, o_protect_error_flag}, 8'h01, "protect error");
    pwr(`WDT_ADDR_RESET_CAUSE, 8'h00);
    pwr(`WDT_ADDR_RESET_CAUSE, 8'h01);
    rd(`WDT_ADDR_RESET_CAUSE, rv);
    chk(rv, 8'h00, "flag clear, set ignored");
    $display("cause test done");
    // Kicks come every five cycles, well inside the 16-cycle period
    do_reset();
    wr(`WDT_ADDR_PERIOD_SEL, 8'h01);
    pwr(`WDT_ADDR_MODE, 8'h98);
    #1 base = n_evt;
    repeat (8) begin
      repeat (3) idle();
      pwr(`WDT_ADDR_MODE, 8'h80);
    end
    idle();
    #1 chk_in(n_evt - base, 0, 0, "kicked events");
    wait_evt(100, n, ev);
    chk({5'h00, ev}, 8'h04, "timeout reset");
    chk_in(n, 13, 19, "timeout time");
    $display("kick test done");
    for (int j = 0; j < 2; j++) begin
      do_reset();
      wr(`WDT_ADDR_PERIOD_SEL, 8'h01);
      wr(`WDT_ADDR_IRQ_CTRL, 8'h07);
      pwr(`WDT_ADDR_MODE, j ? 8'h90 : 8'h80);
      idle();
      i_stop_idle <= 1'b1;
      #1 base = n_evt;
      repeat (40) @(posedge i_mclk);
      #1 chk_in(n_evt - base, 0, 0, "standby events");
      @(posedge i_mclk);
      i_stop_idle <= 1'b0;
      wait_evt(100, n, ev);
      chk({5'h00, ev}, j ? 8'h02 : 8'h01, "after standby");
      chk_in(n, 11, 19, "resumed time");
    end
    $display("standby test done");
    do_reset();
    pwr(`WDT_ADDR_MODE, 8'h80);
    idle();
    #1 base = n_evt;
    repeat (40) @(posedge i_mclk);
    #1 chk_in(n_evt - base, 0, 0, "masked irq");
    rd(`WDT_ADDR_IRQ_CTRL, rv);
    chk(rv & 8'h80, 8'h80, "request pending");
    $display("mask test done");
    tally_and_finish();
  end
endmodule // tb_watchdog_interval_timer
